// ### mfr_pkg.sv
// Constants, enumerations and carrier structs of the motor driver fault response block
package mfr_pkg;

    // ****************************************************************
    // Timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS  = 50;
    localparam int DEGLITCH_NS    = 5000;
    localparam int SLEEP_LIMIT_NS = 20000;
    localparam int DEGLITCH_CYC   = (DEGLITCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SLEEP_CYC      = SLEEP_LIMIT_NS / CLK_PERIOD_NS;
    localparam int SLEEP_CNT_W    = $clog2(SLEEP_CYC + 1);
    localparam logic [SLEEP_CNT_W-1:0] DEGLITCH_CNT = SLEEP_CNT_W'(DEGLITCH_CYC);
    localparam logic [SLEEP_CNT_W-1:0] SLEEP_CNT    = SLEEP_CNT_W'(SLEEP_CYC);

    // ****************************************************************
    // Fixed values of the pin-configured variant and overcurrent response selector codes
    // ****************************************************************
    localparam logic [15:0] HW_OL_DELAY_US   = 16'h012C;  // 300 us
    localparam logic [15:0] HW_TRIP_LEVEL_MA = 16'h1964;  // 6500 mA
    localparam logic [1:0]  OCP_LATCHED      = 2'h0;
    localparam logic [1:0]  OCP_RETRY        = 2'h1;
    localparam logic [1:0]  OCP_REPORT_ONLY  = 2'h2;
    localparam logic        TSD_AUTO         = 1'h1;

    // ****************************************************************
    // Slew rate table, tenths of a volt per microsecond
    // ****************************************************************
    localparam int SLEW_SETTINGS = 6;
    localparam logic [9:0] SLEW_TENTHS [SLEW_SETTINGS] = '{
        10'h214, 10'h154, 10'h0B7, 10'h082, 10'h04F, 10'h01A
    };

    typedef enum logic [1:0] {PIN_LOW, PIN_HIGH, PIN_FLOAT} mfr_pin_level_type;
    typedef enum logic [1:0] {MODE_PHASE_ENABLE, MODE_PWM, MODE_INDEP} mfr_ctrl_mode_type;

    typedef struct packed {
        logic       supply_undervoltage;
        logic       pump_undervoltage;
        logic       overcurrent;
        logic       open_load;
        logic       current_trip;
        logic       overheat_shutdown;
        logic       overtemp_warning;
    } mfr_detect_type;

    typedef struct packed {
        logic       warning_report_enable;
        logic       pump_uv_disable;
        logic [1:0] overcurrent_response_sel;
        logic       passive_openload_enable;
        logic       active_openload_enable;
        logic       regulation_report_enable;
        logic       overheat_recovery_sel;
    } mfr_config_type;

    typedef struct packed {
        logic       overtemp_warning;
        logic       supply_undervoltage;
        logic       pump_undervoltage;
        logic       overcurrent;
        logic       overheat_shutdown;
        logic       open_load;
        logic       current_trip;
        logic       fault_summary;
    } mfr_status_type;

    typedef struct packed {
        logic                     powered;
        logic                     sleep_n_prev;
        logic [SLEEP_CNT_W-1:0]   low_cnt;
        logic                     sleeping;
        mfr_ctrl_mode_type        ctrl_mode;
        logic                     ocp_latch;
        logic                     tsd_latch;
        logic                     old_latch;
        logic                     retrying;
        mfr_status_type           status;
        logic                     fault_drive;
        logic [1:0]               bridge_hiz;
        logic                     logic_reset;
        logic                     pump_enable;
        logic [9:0]               slew_rate;
    } mfr_state_type;

endpackage

// ### mfr_fault_response.sv
// Fault response, recovery and pin configuration logic of the H-bridge motor driver
module mfr_fault_response
    import mfr_pkg::*;
#(
    parameter int RETRY_CYC = 80000  // Overcurrent retry delay in clock cycles
) (
    input  wire logic                      ref_clk_i,              // 20 MHz clock
    input  wire logic                      sys_rst_i,              // Async reset, high
    input  wire mfr_pkg::mfr_detect_type   detect_i,               // Detector flags
    input  wire mfr_pkg::mfr_config_type   config_i,               // Serial variant settings
    input  wire logic                      hw_variant_i,           // Pin-configured variant
    input  wire logic                      openload_disable_n_i,   // Pin variant OL control
    input  wire logic                      regulation_enable_n_i,  // Pin variant trip control
    input  wire mfr_pkg::mfr_pin_level_type mode_pin_i,            // Tri-level mode pin
    input  wire logic [2:0]                slew_sel_i,             // Slew setting select
    input  wire logic [1:0]                hiz_req_i,              // Per-output Hi-Z request, serial variant only
    input  wire logic                      fault_clear_cmd_i,      // Fault clear pulse
    input  wire logic                      sleep_n_i,              // Sleep pin, low active
    input  wire logic                      fault_line_i,           // Fault wire level
    output logic                           fault_out_n_o,          // Fault pin drive value
    output logic                           fault_out_n_oe_o,       // Fault pin enable
    output logic [1:0]                     bridge_hiz_o,           // Half-bridge Hi-Z
    output logic                           logic_reset_o,          // Core logic reset
    output logic                           pump_enable_o,          // Charge pump enable
    output logic                           sleep_o,                // Device in sleep
    output mfr_pkg::mfr_status_type        status_o,               // Status bits
    output mfr_pkg::mfr_ctrl_mode_type     ctrl_mode_o,            // Latched control mode
    output logic                           passive_ol_en_o,        // Effective passive OL
    output logic                           active_ol_en_o,         // Effective active OL
    output logic                           regulation_en_o,        // Current regulation on
    output logic [15:0]                    trip_level_ma_o,        // Pin variant trip level
    output logic [15:0]                    ol_delay_us_o,          // Pin variant OL delay
    output logic [9:0]                     slew_rate_o,            // Slew, 0.1 V/us units
    output logic                           fault_line_low_o        // Fault wire seen low
);
    import mfr_pkg::*;

    localparam int RETRY_W = $clog2(RETRY_CYC + 1);

    mfr_state_type       state;
    mfr_state_type       next_state;
    logic [RETRY_W-1:0]  retry_cnt;
    logic [RETRY_W-1:0]  next_retry_cnt;
    mfr_config_type      eff;
    logic                reset_pulse;
    logic                clr;
    logic                ocp_ev;
    logic                ocp_rep;
    logic                ocp_hiz;
    logic                tsd_act;
    logic                ol_en;
    logic                pump_undervoltage_act;
    logic                any_fault;

    // ****************************************************************
    // Effective configuration
    // ****************************************************************
    always_comb begin
        eff = config_i;
        if (hw_variant_i) begin
            eff.pump_uv_disable          = 1'b0;
            eff.overcurrent_response_sel = OCP_LATCHED;
            eff.overheat_recovery_sel    = TSD_AUTO;
            eff.passive_openload_enable  = ~openload_disable_n_i;
            eff.active_openload_enable   = ~openload_disable_n_i;
            eff.warning_report_enable    = 1'b0;
            eff.regulation_report_enable = 1'b0;
        end
    end

    // ****************************************************************
    // Fault evaluation and state update
    // ****************************************************************
    always_comb begin
        next_state     = state;
        next_retry_cnt = retry_cnt;
        next_state.sleep_n_prev = sleep_n_i;
        // Valid low pulse ends on the rising edge of sleep_n
        reset_pulse = sleep_n_i && !state.sleep_n_prev
                      && (state.low_cnt >= DEGLITCH_CNT);
        if (!sleep_n_i) begin
            if (state.low_cnt < SLEEP_CNT) begin
                next_state.low_cnt = state.low_cnt + 1'b1;
            end else begin
                next_state.sleeping = 1'b1;
            end
        end else begin
            next_state.low_cnt  = '0;
            next_state.sleeping = 1'b0;
        end
        // Undervoltage resets the logic, so it wipes latches too
        clr = fault_clear_cmd_i || reset_pulse || detect_i.supply_undervoltage;

        // Mode pin sampled only at power-up and at the end of a valid sleep_n low pulse
        next_state.powered = 1'b1;
        if (!state.powered || reset_pulse) begin
            case (mode_pin_i)
                PIN_LOW:   next_state.ctrl_mode = MODE_PHASE_ENABLE;
                PIN_HIGH:  next_state.ctrl_mode = MODE_PWM;
                default:   next_state.ctrl_mode = MODE_INDEP;
            endcase
        end

        // Overcurrent
        ocp_ev = detect_i.overcurrent && (eff.overcurrent_response_sel != 2'h3);
        next_state.ocp_latch = (state.ocp_latch && !clr)
            || (detect_i.overcurrent && eff.overcurrent_response_sel == OCP_LATCHED);
        // Retry timer reloads while overcurrent persists
        if (detect_i.overcurrent && eff.overcurrent_response_sel == OCP_RETRY) begin
            next_state.retrying = 1'b1;
            next_retry_cnt      = RETRY_W'(RETRY_CYC);
        end else if (state.retrying) begin
            if (retry_cnt <= RETRY_W'(1)) begin
                next_state.retrying = 1'b0;
            end
            next_retry_cnt = retry_cnt - 1'b1;
        end
        if (eff.overcurrent_response_sel != OCP_RETRY) begin
            next_state.retrying = 1'b0;
        end
        ocp_hiz = state.ocp_latch || state.retrying
                  || (detect_i.overcurrent && eff.overcurrent_response_sel <= OCP_RETRY);
        ocp_rep = ocp_hiz || (detect_i.overcurrent
                  && eff.overcurrent_response_sel == OCP_REPORT_ONLY);

        // Overheat: status stays latched, action depends on selector
        next_state.tsd_latch = (state.tsd_latch && !clr) || detect_i.overheat_shutdown;
        tsd_act = eff.overheat_recovery_sel ? detect_i.overheat_shutdown
                                            : state.tsd_latch || detect_i.overheat_shutdown;

        // Open load
        ol_en = eff.passive_openload_enable || eff.active_openload_enable;
        next_state.old_latch = (state.old_latch && !clr)
                               || (detect_i.open_load && ol_en);

        pump_undervoltage_act = detect_i.pump_undervoltage && !eff.pump_uv_disable;

        any_fault = detect_i.supply_undervoltage || pump_undervoltage_act || ocp_rep || tsd_act
                    || state.old_latch
                    || (detect_i.current_trip && eff.regulation_report_enable)
                    || (detect_i.overtemp_warning && eff.warning_report_enable);
        next_state.fault_drive = any_fault;

        next_state.status.overtemp_warning    = detect_i.overtemp_warning;
        next_state.status.supply_undervoltage = detect_i.supply_undervoltage;
        next_state.status.pump_undervoltage   = pump_undervoltage_act;
        next_state.status.overcurrent         = (state.status.overcurrent && !clr) || ocp_ev;
        next_state.status.overheat_shutdown   = state.tsd_latch || detect_i.overheat_shutdown;
        next_state.status.open_load           = state.old_latch;
        next_state.status.current_trip        = detect_i.current_trip;
        next_state.status.fault_summary       = any_fault;

        // Warning and current trip never steer the bridge
        next_state.bridge_hiz = {2{detect_i.supply_undervoltage || pump_undervoltage_act || ocp_hiz
                                   || tsd_act || state.sleeping}};
        if (!hw_variant_i) begin
            next_state.bridge_hiz = next_state.bridge_hiz | hiz_req_i;
        end
        next_state.logic_reset = detect_i.supply_undervoltage;
        next_state.pump_enable = !state.sleeping;

        // Unused selects fall back to the slowest setting
        if (slew_sel_i < 3'(SLEW_SETTINGS)) begin
            next_state.slew_rate = SLEW_TENTHS[slew_sel_i];
        end else begin
            next_state.slew_rate = SLEW_TENTHS[SLEW_SETTINGS-1];
        end
    end

    always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state     <= '0;
            retry_cnt <= '0;
        end else begin
            state     <= next_state;
            retry_cnt <= next_retry_cnt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign fault_out_n_o    = 1'b0;
    assign fault_out_n_oe_o = state.fault_drive;
    assign fault_line_low_o = !fault_line_i;
    assign bridge_hiz_o     = state.bridge_hiz;
    assign logic_reset_o    = state.logic_reset;
    assign pump_enable_o    = state.pump_enable;
    assign sleep_o          = state.sleeping;
    assign status_o         = state.status;
    assign ctrl_mode_o      = state.ctrl_mode;
    assign passive_ol_en_o  = eff.passive_openload_enable;
    assign active_ol_en_o   = eff.active_openload_enable;
    assign regulation_en_o  = hw_variant_i && !regulation_enable_n_i;
    assign trip_level_ma_o  = HW_TRIP_LEVEL_MA;
    assign ol_delay_us_o    = HW_OL_DELAY_US;
    assign slew_rate_o      = state.slew_rate;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (sys_rst_i);

    warn_status_a: assert property (
        ##1 $past(detect_i.overtemp_warning) |-> status_o.overtemp_warning)
        else $error("warning status not set");
    warn_clear_a: assert property (
        !detect_i.overtemp_warning |=> !status_o.overtemp_warning)
        else $error("warning status not cleared");
    warn_report_a: assert property (
        detect_i.overtemp_warning && eff.warning_report_enable |=> fault_out_n_oe_o)
        else $error("warning not reported");
    uv_response_a: assert property (
        detect_i.supply_undervoltage |=> bridge_hiz_o == 2'h3 && logic_reset_o
                                         && fault_out_n_oe_o)
        else $error("undervoltage response missing");
    pump_undervoltage_ignore_a: assert property (
        eff.pump_uv_disable |=> !status_o.pump_undervoltage)
        else $error("disabled pump check acted");
    ocp_latched_a: assert property (
        detect_i.overcurrent && eff.overcurrent_response_sel == OCP_LATCHED
        ##1 (!clr && !detect_i.overcurrent)[*3] |=> bridge_hiz_o == 2'h3)
        else $error("latched overcurrent released");
    ocp_report_only_a: assert property (
        detect_i.overcurrent && eff.overcurrent_response_sel == OCP_REPORT_ONLY
        && !state.ocp_latch |=> fault_out_n_oe_o && !state.ocp_latch)
        else $error("report-only overcurrent latched");
    ol_held_a: assert property (
        state.old_latch && !clr |=> state.old_latch ##0 fault_out_n_oe_o)
        else $error("open load report lost");
    tsd_auto_a: assert property (
        hw_variant_i && !detect_i.overheat_shutdown && !detect_i.supply_undervoltage
        && !pump_undervoltage_act && !ocp_hiz && !state.sleeping && !state.fault_drive ##0 !any_fault
        |=> bridge_hiz_o == 2'h0)
        else $error("pin variant bridge stuck in Hi-Z");
    mode_hold_a: assert property (
        state.powered && !reset_pulse |=> $stable(ctrl_mode_o))
        else $error("mode changed without latch event");
    pump_on_a: assert property (
        detect_i.overtemp_warning && !state.sleeping |=> pump_enable_o)
        else $error("pump off during warning");
    ocp_ignore_a: assert property (
        detect_i.overcurrent && eff.overcurrent_response_sel == 2'h3
        && !status_o.overcurrent |=> !status_o.overcurrent)
        else $error("ignored overcurrent reported");
    ocp_retry_a: assert property (
        detect_i.overcurrent && eff.overcurrent_response_sel == OCP_RETRY
        |=> bridge_hiz_o == 2'h3 && fault_out_n_oe_o && state.retrying)
        else $error("retrying overcurrent not acted on");
    pump_undervoltage_response_a: assert property (
        detect_i.pump_undervoltage && !eff.pump_uv_disable
        |=> bridge_hiz_o == 2'h3 && fault_out_n_oe_o)
        else $error("pump undervoltage not acted on");
    uv_recover_a: assert property (
        $fell(detect_i.supply_undervoltage) |=> !logic_reset_o)
        else $error("logic reset held after undervoltage");
    ol_ignore_a: assert property (
        detect_i.open_load && !ol_en && !state.old_latch |=> !state.old_latch)
        else $error("disabled open load latched");
    itrip_report_a: assert property (
        detect_i.current_trip && eff.regulation_report_enable |=> fault_out_n_oe_o)
        else $error("current trip not reported");
    tsd_latched_a: assert property (
        state.tsd_latch && !eff.overheat_recovery_sel && !clr |=> bridge_hiz_o == 2'h3)
        else $error("latched overheat released");
    hw_no_split_a: assert property (
        hw_variant_i |=> bridge_hiz_o[0] == bridge_hiz_o[1])
        else $error("pin variant outputs split");
    mode_latch_a: assert property (
        reset_pulse && mode_pin_i == PIN_LOW |=> ctrl_mode_o == MODE_PHASE_ENABLE)
        else $error("mode not latched on wake");
    sleep_clear_a: assert property (
        reset_pulse && !detect_i.open_load && !detect_i.overcurrent
        |=> !state.old_latch && !state.ocp_latch)
        else $error("sleep pulse left latch set");

    // Main scenarios
    ocp_retry_c: cover property (
        detect_i.overcurrent && eff.overcurrent_response_sel == OCP_RETRY ##1 state.retrying);
    reset_pulse_c: cover property (reset_pulse && state.old_latch);
    sleep_entry_c: cover property (!state.sleeping ##1 state.sleeping);
    tsd_latch_c: cover property (state.tsd_latch && !eff.overheat_recovery_sel);
    ol_refused_c: cover property (detect_i.open_load && !ol_en);

endmodule

// ### mfr_host_model.sv
// Host controller model driving the fault clear and sleep pins
module mfr_host_model (
    input  wire logic ref_clk_i,          // Bench clock
    output logic      fault_clear_cmd_o,  // Fault clear pulse
    output logic      sleep_n_o           // Sleep pin, low active
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        fault_clear_cmd_o = 1'b0;
        sleep_n_o = 1'b1;
    end
    // ****************************************************************
    // Host pin actions
    // ****************************************************************
    task automatic clear_pulse;
        @(posedge ref_clk_i);
        #1 fault_clear_cmd_o = 1'b1;
        @(posedge ref_clk_i);
        #1 fault_clear_cmd_o = 1'b0;
    endtask
    // Mode pin must already hold the wanted value
    task automatic sleep_pulse(input int cycles);
        @(posedge ref_clk_i);
        #1 sleep_n_o = 1'b0;
        repeat (cycles) @(posedge ref_clk_i);
        #1 sleep_n_o = 1'b1;
    endtask
endmodule

// ### tb.sv
// Self-checking testbench of the motor driver fault response block
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import mfr_pkg::*;
    logic ref_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    mfr_detect_type det = '0;
    mfr_config_type cfg = '0;
    logic hw = 1'b1, ol_dis_n = 1'b1, reg_en_n = 1'b1, fclr, slp_n, wire_lvl;
    mfr_pin_level_type pin = PIN_HIGH;
    logic [2:0] slew_sel = 3'h0;
    logic [1:0] hiz_req = 2'h0;
    logic oe, drv, rst_o, pump, slp_o, pol, aol, regen, lowseen;
    logic [1:0] hiz;
    mfr_status_type st;
    mfr_ctrl_mode_type mode;
    logic [15:0] trip, oldly;
    logic [9:0] slew;
    int fail_count = 0;
    int checks = 0;
    localparam mfr_pin_level_type PINS [3] = '{PIN_LOW, PIN_HIGH, PIN_FLOAT};
    localparam mfr_ctrl_mode_type MODES [3] = '{MODE_PHASE_ENABLE, MODE_PWM, MODE_INDEP};
    localparam logic [9:0] SLEW [6] = '{10'h214, 10'h154, 10'h0B7, 10'h082, 10'h04F, 10'h01A};
    // Open-drain fault wire with pull-up
    assign wire_lvl = oe ? drv : 1'b1;
    initial begin
        forever #25 ref_clk_i = ~ref_clk_i;
    end
    mfr_host_model u_mfr_host_model (.ref_clk_i(ref_clk_i), .fault_clear_cmd_o(fclr),
        .sleep_n_o(slp_n));
    mfr_fault_response #(.RETRY_CYC(20)) u_mfr_fault_response (.ref_clk_i(ref_clk_i),
        .sys_rst_i(sys_rst_i), .detect_i(det), .config_i(cfg), .hw_variant_i(hw),
        .openload_disable_n_i(ol_dis_n), .regulation_enable_n_i(reg_en_n), .mode_pin_i(pin),
        .slew_sel_i(slew_sel), .hiz_req_i(hiz_req), .fault_clear_cmd_i(fclr),
        .sleep_n_i(slp_n), .fault_line_i(wire_lvl), .fault_out_n_o(drv),
        .fault_out_n_oe_o(oe), .bridge_hiz_o(hiz), .logic_reset_o(rst_o),
        .pump_enable_o(pump), .sleep_o(slp_o), .status_o(st), .ctrl_mode_o(mode),
        .passive_ol_en_o(pol), .active_ol_en_o(aol), .regulation_en_o(regen),
        .trip_level_ma_o(trip), .ol_delay_us_o(oldly), .slew_rate_o(slew),
        .fault_line_low_o(lowseen));
    // ****************************************************************
    // Shared tasks
    // ****************************************************************
    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask
    task automatic final_report;
        if (fail_count == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        repeat (60000) @(posedge ref_clk_i);
        fail_count++;
        final_report();
    end
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    initial begin
        repeat (20) @(posedge ref_clk_i);
        #1 sys_rst_i = 1'b0;
        step(2);
        chk("mode", mode, MODE_PWM);
        pin = PIN_FLOAT;
        step(3);
        chk("mode", mode, MODE_PWM);
        for (int i = 0; i < 3; i++) begin
            pin = PINS[i];
            u_mfr_host_model.sleep_pulse(150);
            step(3);
            chk("mode", mode, MODES[i]);
        end
        hw = 1'b0;
        det.overtemp_warning = 1'b1;
        step(2);
        chk("otw", st.overtemp_warning, 1);
        chk("oe", oe, 0);
        chk("hiz", hiz, 0);
        chk("pump", pump, 1);
        cfg.warning_report_enable = 1'b1;
        step(2);
        chk("summary", st.fault_summary, 1);
        chk("wirelow", lowseen, 1);
        det.overtemp_warning = 1'b0;
        step(2);
        chk("otw", st.overtemp_warning, 0);
        chk("oe", oe, 0);
        det.supply_undervoltage = 1'b1;
        step(2);
        chk("uv", {oe, hiz, rst_o, st.supply_undervoltage}, 5'h1F);
        det.supply_undervoltage = 1'b0;
        step(2);
        chk("uv", {oe, hiz, rst_o, st.supply_undervoltage}, 5'h00);
        for (int d = 0; d < 2; d++) begin
            cfg.pump_uv_disable = d[0];
            det.pump_undervoltage = 1'b1;
            step(2);
            chk("pump_undervoltage", {oe, hiz, st.pump_undervoltage}, {4{~d[0]}});
            det.pump_undervoltage = 1'b0;
            step(2);
            chk("pump_undervoltage", {oe, hiz, st.pump_undervoltage}, 4'h0);
        end
        for (int s = 0; s < 4; s++) begin
            cfg.overcurrent_response_sel = 2'(s);
            det.overcurrent = 1'b1;
            step(2);
            chk("ocp_oe", oe, 16'(s < 3));
            chk("ocp_hiz", hiz, (s < 2) ? 2'h3 : 2'h0);
            det.overcurrent = 1'b0;
            step(5);
            chk("ocp_hold", hiz, (s < 2) ? 2'h3 : 2'h0);
            chk("ocp_st", st.overcurrent, 16'(s < 3));
            step(25);
            chk("ocp_retry", hiz, (s == 0) ? 2'h3 : 2'h0);
            u_mfr_host_model.clear_pulse();
            step(3);
            chk("ocp_clr", {oe, hiz, st.overcurrent}, 4'h0);
        end
        for (int e = 0; e < 3; e++) begin
            {cfg.active_openload_enable, cfg.passive_openload_enable} = 2'(e);
            det.open_load = 1'b1;
            step(2);
            det.open_load = 1'b0;
            step(3);
            chk("ol", {oe, hiz, st.open_load}, {e != 0, 2'h0, e != 0});
            u_mfr_host_model.sleep_pulse(50);
            step(3);
            chk("ol_glitch", oe, 16'(e != 0));
            u_mfr_host_model.clear_pulse();
            step(3);
            chk("ol_clr", {oe, st.open_load}, 2'h0);
        end
        for (int r = 0; r < 2; r++) begin
            cfg.regulation_report_enable = r[0];
            det.current_trip = 1'b1;
            step(2);
            chk("itrip", {oe, hiz, st.current_trip}, {r[0], 2'h0, 1'b1});
            det.current_trip = 1'b0;
            step(2);
            chk("itrip", {oe, st.current_trip}, 2'h0);
        end
        for (int t = 0; t < 2; t++) begin
            cfg.overheat_recovery_sel = t[0];
            det.overheat_shutdown = 1'b1;
            step(2);
            chk("tsd", {oe, hiz}, 3'h7);
            det.overheat_shutdown = 1'b0;
            step(3);
            chk("tsd_rec", hiz, {2{~t[0]}});
            u_mfr_host_model.sleep_pulse(150);
            step(3);
            chk("tsd_clr", {oe, hiz, st.overheat_shutdown, slp_o}, 5'h0);
        end
        fork
            u_mfr_host_model.sleep_pulse(450);
            begin
                step(420);
                chk("sleep", {slp_o, pump, hiz}, 4'hB);
            end
        join
        step(3);
        chk("wake", {slp_o, pump, hiz}, 4'h4);
        hw = 1'b1;
        // Settings opposite to the fixed pin-variant values, except warning_report_enable
        cfg = 8'h72;
        ol_dis_n = 1'b0;
        reg_en_n = 1'b0;
        hiz_req = 2'h1;
        step(2);
        chk("trip", trip, 16'h1964);
        chk("oldly", oldly, 16'h012C);
        chk("ol_en", {pol, aol, regen}, 3'h7);
        chk("hiz_req", hiz, 0);
        det.pump_undervoltage = 1'b1;
        step(2);
        chk("hw_pump_undervoltage", hiz, 3);
        det = '{overcurrent: 1'b1, default: 1'b0};
        step(2);
        det = '0;
        step(5);
        chk("hw_ocp", hiz, 3);
        u_mfr_host_model.clear_pulse();
        det.overheat_shutdown = 1'b1;
        step(2);
        det = '0;
        step(3);
        chk("hw_tsd", hiz, 0);
        for (int i = 0; i < 8; i++) begin
            slew_sel = 3'(i);
            step(2);
            chk("slew", slew, SLEW[(i > 5) ? 5 : i]);
        end
        final_report();
    end
endmodule
